/* File: inc/strap_cfg.svh */
// Constants for the reset strap capture and device configuration block
`ifndef STRAP_CFG_SVH
`define STRAP_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define CFG_WINDOW_FIRST 32'h019c0200
`define CFG_WINDOW_LAST 32'h019c02ff
`define STATUS_ADDR 32'h019c0300
`define CFG_CLKSRC_BIT 4
`define CFG_CLKSRC_RESET 1'b0

// ****************************************************************
// Captured strap vector and status register layout
// ****************************************************************
`define STRAP_WIDTH 5
`define STRAP_BYTE_ORDER 0
`define STRAP_FIX 1
`define STRAP_BOOT_LO 2
`define STRAP_BOOT_HI 3
`define STRAP_CLOCK 4
`define STATUS_VALID_BIT 5
`define STATUS_FAULT_BIT 6

`endif

/* File: inc/strap_pkg.sv */
// Types shared by the reset strap configuration block
`default_nettype none

package strap_pkg;

   // Boot strap codes
   typedef enum logic [1:0] {
      BOOT_EMULATION = 2'b00,
      BOOT_ROM_8 = 2'b01,
      BOOT_ROM_16 = 2'b10,
      BOOT_RESERVED = 2'b11
   } boot_mode_type;

   // Register and decode state of the top module
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic clk_sel;
      logic valid;
      logic little;
      logic fix_on;
      logic [1:0] boot;
      logic emu;
      logic rom;
      logic rom16;
      logic x4;
      logic pin_src;
      logic fault;
   } main_state_type;

endpackage : strap_pkg

`default_nettype wire

/* File: verilog/strap_sync.sv */
// Two-flop synchroniser for a group of static pin levels
`default_nettype none

module strap_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock_in,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_state_type;

   sync_state_type state;
   sync_state_type next_state;

   // No reset here: the chain must keep sampling through reset so that
   // the capture stage sees settled levels right at the release
   always_comb begin
      next_state = state;
      next_state.stage1 = pin_in;
      next_state.stage2 = state.stage1;
   end

   // Register the chain
   always_ff @(posedge clock_in) begin
      state <= next_state;
   end

   assign level_out = state.stage2;

endmodule : strap_sync

`default_nettype wire

/* File: verilog/strap_capture.sv */
// Capture-once holder for strap levels, armed by reset
`default_nettype none

module strap_capture #(
   parameter int WIDTH = 1
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [WIDTH-1:0] level_in,
   output logic [WIDTH-1:0] held_out,
   output logic valid_out
);

   typedef struct packed {
      logic [WIDTH-1:0] held;
      logic valid;
   } capture_state_type;

   capture_state_type state;
   capture_state_type next_state;

   // Take the levels at the first edge after release, then freeze
   always_comb begin
      next_state = state;
      if (!state.valid) begin
         next_state.held = level_in;
         next_state.valid = 1'b1;
      end
   end

   // Synchronous reset rearms the capture
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign held_out = state.held;
   assign valid_out = state.valid;

endmodule : strap_capture

`default_nettype wire

/* File: verilog/reset_strap_device_config.sv */
// Reset strap capture, decode and the device configuration register
//
// The Wishbone slave port was decided locally.
`include "strap_cfg.svh"
`default_nettype none

module reset_strap_device_config
   import strap_pkg::*;
#(
   parameter bit LATER_VARIANT = 1'b1,
   parameter bit FIX_SUPPORTED = 1'b1
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic cyc_in,
   input wire logic stb_in,
   input wire logic we_in,
   input wire logic [31:0] adr_in,
   input wire logic [3:0] sel_in,
   input wire logic [31:0] dat_in,
   output logic ack_out,
   output logic [31:0] dat_out,
   input wire logic byte_order_strap_in,
   input wire logic memif_byte_order_fix_strap_in,
   input wire logic [1:0] boot_mode_strap_in,
   input wire logic clock_mode_strap_in,
   output logic config_valid_out,
   output logic byte_order_select_out,
   output logic memif_byte_order_fix_out,
   output logic [1:0] boot_mode_out,
   output logic boot_emulation_out,
   output logic boot_rom_out,
   output logic boot_rom_width16_out,
   output logic pll_multiply_x4_out,
   output logic input_clock_pin_src_out,
   output logic memif_clock_source_select_out,
   output logic strap_fault_out
);

   // ****************************************************************
   // Strap synchronising and capture
   // ****************************************************************
   logic [`STRAP_WIDTH-1:0] strap_pins;
   logic [`STRAP_WIDTH-1:0] strap_levels;
   logic [`STRAP_WIDTH-1:0] cap;
   logic cap_valid;

   // Pack the strap pins in the fixed layout
   assign strap_pins = {clock_mode_strap_in, boot_mode_strap_in,
                        memif_byte_order_fix_strap_in, byte_order_strap_in};

   strap_sync #(
      .WIDTH(`STRAP_WIDTH)
   ) strap_sync_inst (
      .clock_in(clock_in),
      .pin_in(strap_pins),
      .level_out(strap_levels)
   );

   // Straps are only trusted at release because the board holds them
   strap_capture #(
      .WIDTH(`STRAP_WIDTH)
   ) strap_capture_inst (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .level_in(strap_levels),
      .held_out(cap),
      .valid_out(cap_valid)
   );

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   main_state_type state;
   main_state_type next_state;
   logic req;
   logic in_cfg;
   logic in_status;
   logic [1:0] cap_boot;
   logic [31:0] cfg_word;
   logic [31:0] status_word;

   assign req = cyc_in & stb_in;
   assign in_cfg = (adr_in >= `CFG_WINDOW_FIRST) && (adr_in <= `CFG_WINDOW_LAST);
   assign in_status = (adr_in == `STATUS_ADDR);
   assign cap_boot = cap[`STRAP_BOOT_HI:`STRAP_BOOT_LO];

   // Only bit 4 is stored; reserved bits read back as zero
   always_comb begin
      cfg_word = 32'h0000_0000;
      cfg_word[`CFG_CLKSRC_BIT] = state.clk_sel;
      status_word = 32'h0000_0000;
      status_word[`STRAP_WIDTH-1:0] = cap;
      status_word[`STATUS_VALID_BIT] = state.valid;
      status_word[`STATUS_FAULT_BIT] = state.fault;
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_state = state;
      // One wait state, then ack for one cycle
      next_state.ack = req & ~state.ack;
      if (req && !state.ack) begin
         if (in_cfg) begin
            next_state.rdata = cfg_word;
         end else if (in_status) begin
            next_state.rdata = status_word;
         end else begin
            next_state.rdata = 32'h0000_0000; // Unmapped reads zero
         end
      end
      // Write lands on the edge where the master sees ack
      if (req && state.ack && we_in && in_cfg && sel_in[0]) begin
         next_state.clk_sel = dat_in[`CFG_CLKSRC_BIT];
      end
      // Decode the held straps once they are valid
      if (cap_valid) begin
         next_state.valid = 1'b1;
         next_state.little = cap[`STRAP_BYTE_ORDER];
         // Fix only engages when big-endian and the fix strap is low
         next_state.fix_on = FIX_SUPPORTED & ~cap[`STRAP_BYTE_ORDER]
                             & ~cap[`STRAP_FIX];
         next_state.boot = cap_boot;
         next_state.emu = (cap_boot == BOOT_EMULATION);
         next_state.rom = (cap_boot == BOOT_ROM_8) || (cap_boot == BOOT_ROM_16);
         next_state.rom16 = (cap_boot == BOOT_ROM_16);
         next_state.x4 = ~LATER_VARIANT & cap[`STRAP_CLOCK];
         next_state.pin_src = LATER_VARIANT & cap[`STRAP_CLOCK];
         // Flag board misuse rather than guess a boot source
         next_state.fault = (cap_boot == BOOT_RESERVED)
                            | (LATER_VARIANT & ~cap[`STRAP_CLOCK])
                            | (FIX_SUPPORTED & ~cap[`STRAP_BYTE_ORDER]
                               & cap[`STRAP_FIX]);
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         state <= '0;
         state.clk_sel <= `CFG_CLKSRC_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Outputs straight from the state flops
   assign ack_out = state.ack;
   assign dat_out = state.rdata;
   assign config_valid_out = state.valid;
   assign byte_order_select_out = state.little;
   assign memif_byte_order_fix_out = state.fix_on;
   assign boot_mode_out = state.boot;
   assign boot_emulation_out = state.emu;
   assign boot_rom_out = state.rom;
   assign boot_rom_width16_out = state.rom16;
   assign pll_multiply_x4_out = state.x4;
   assign input_clock_pin_src_out = state.pin_src;
   assign memif_clock_source_select_out = state.clk_sel;
   assign strap_fault_out = state.fault;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);

   AST_BYTE_ORDER: assert property (
      config_valid_out |-> byte_order_select_out == cap[`STRAP_BYTE_ORDER])
      else $error("byte order does not follow the captured strap");

   AST_FIX_DEFAULT: assert property (
      config_valid_out && cap[`STRAP_FIX] |-> !memif_byte_order_fix_out)
      else $error("fix engaged with fix strap high");

   AST_BOOT_EMU: assert property (
      config_valid_out && cap_boot == 2'h0 |-> boot_emulation_out && !boot_rom_out)
      else $error("emulation boot not selected for code 00");

   AST_BOOT_ROM8: assert property (
      config_valid_out && cap_boot == 2'h1 |-> boot_rom_out && !boot_rom_width16_out)
      else $error("8-bit rom boot not selected for code 01");

   AST_BOOT_ROM16: assert property (
      config_valid_out && cap_boot == 2'h2 |-> boot_rom_out && boot_rom_width16_out)
      else $error("16-bit rom boot not selected for code 10");

   AST_CLK_MODE: assert property (
      config_valid_out && !LATER_VARIANT |-> pll_multiply_x4_out == cap[`STRAP_CLOCK])
      else $error("pll mode does not follow clock strap");

   AST_CLK_RESERVED: assert property (
      config_valid_out && LATER_VARIANT && !cap[`STRAP_CLOCK]
      |-> strap_fault_out && !input_clock_pin_src_out)
      else $error("reserved clock strap not flagged");

   AST_CLKSEL_WRITE: assert property (
      req && ack_out && we_in && in_cfg && sel_in[0]
      |=> memif_clock_source_select_out == $past(dat_in[`CFG_CLKSRC_BIT]))
      else $error("clock source bit not written at ack");

   AST_CLKSEL_HOLD: assert property (
      !(req && ack_out && we_in) |=> $stable(memif_clock_source_select_out))
      else $error("clock source bit changed without a write");

   AST_WINDOW_READ: assert property (
      req && !ack_out && !we_in && in_cfg
      |=> ack_out && dat_out == {27'h0, memif_clock_source_select_out, 4'h0})
      else $error("window read answered wrongly");

   AST_CAPTURE_HOLD: assert property (
      config_valid_out |=> config_valid_out && $stable(boot_mode_out)
      && $stable(byte_order_select_out))
      else $error("captured straps changed after release");

   AST_ACK_PULSE: assert property (
      ack_out |=> !ack_out)
      else $error("ack held longer than one cycle");

   COV_BOOT16: cover property (config_valid_out && boot_rom_width16_out);
   COV_CLKSEL: cover property (!memif_clock_source_select_out ##1
                               memif_clock_source_select_out);
   COV_STATUS: cover property (req && ack_out && !we_in && in_status);
   COV_FAULT: cover property (config_valid_out && strap_fault_out);

endmodule : reset_strap_device_config

`default_nettype wire

/* File: sim/strap_board.sv */
// Board model: strap pull levels and the reset source of the device
`default_nettype none

module strap_board #(
   parameter logic [4:0] PULL_LEVELS = 5'b10111
) (
   input wire logic clock_in,
   input wire logic reset_req_in,
   input wire logic [4:0] strap_value_in,
   input wire logic wiggle_in,
   output logic rst_n_out,
   output logic [4:0] strap_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Reset pulse and strap hold
   // ****************************************
   // Pull levels give little-endian, fix high, boot 01 and clock high
   logic [2:0] count = 3'h4;
   logic [4:0] held = PULL_LEVELS;

   // Straps only change together with a new reset, never while it is low
   always_ff @(posedge clock_in) begin
      if (reset_req_in) begin
         count <= 3'h4;
         held <= strap_value_in;
      end else if (count != 3'h0) begin
         count <= count - 3'h1;
      end
   end

   // Wiggling after release probes that the device ignores later changes
   assign rst_n_out = (count == 3'h0);
   assign strap_out = (wiggle_in && rst_n_out) ? ~held : held;
endmodule : strap_board

`default_nettype wire

/* File: sim/reset_strap_device_config_test.sv */
// Self-checking bench for the reset strap configuration block
`include "strap_cfg.svh"
`default_nettype none

module reset_strap_device_config_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, req = 1'b0, wig = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [31:0] adr = 32'h0, wdat = 32'h0;
   logic [4:0] sv = 5'b10111;
   logic [3:0] sel = 4'hf;
   logic rst_n, ack, valid, order, fixo, emu, rom, w16, pin, csel, fault, x4, x4l, pinl;
   logic [1:0] boot;
   logic [31:0] rdat;
   logic [4:0] st;
   int errors = 0, n_checks = 0;

   // ****************************************
   // Clock, board and the two variants
   // ****************************************
   initial begin
      forever #12.5 clk = ~clk;
   end

   strap_board strap_board_inst (.clock_in(clk), .reset_req_in(req), .strap_value_in(sv),
      .wiggle_in(wig), .rst_n_out(rst_n), .strap_out(st));

   reset_strap_device_config reset_strap_device_config_inst (.clock_in(clk), .rst_n_in(rst_n),
      .cyc_in(cyc), .stb_in(stb), .we_in(we), .adr_in(adr), .sel_in(sel), .dat_in(wdat),
      .ack_out(ack), .dat_out(rdat), .byte_order_strap_in(st[0]),
      .memif_byte_order_fix_strap_in(st[1]), .boot_mode_strap_in(st[3:2]),
      .clock_mode_strap_in(st[4]), .config_valid_out(valid), .byte_order_select_out(order),
      .memif_byte_order_fix_out(fixo), .boot_mode_out(boot), .boot_emulation_out(emu),
      .boot_rom_out(rom), .boot_rom_width16_out(w16), .pll_multiply_x4_out(x4l),
      .input_clock_pin_src_out(pin), .memif_clock_source_select_out(csel),
      .strap_fault_out(fault));

   // Original variant shares all inputs; only its multiplier and pin source outputs are watched
   reset_strap_device_config #(.LATER_VARIANT(1'b0)) reset_strap_device_config_orig_inst (
      .clock_in(clk), .rst_n_in(rst_n), .cyc_in(cyc), .stb_in(stb), .we_in(we),
      .adr_in(adr), .sel_in(sel), .dat_in(wdat), .ack_out(), .dat_out(),
      .byte_order_strap_in(st[0]), .memif_byte_order_fix_strap_in(st[1]),
      .boot_mode_strap_in(st[3:2]), .clock_mode_strap_in(st[4]), .config_valid_out(),
      .byte_order_select_out(), .memif_byte_order_fix_out(), .boot_mode_out(),
      .boot_emulation_out(), .boot_rom_out(), .boot_rom_width16_out(),
      .pll_multiply_x4_out(x4), .input_clock_pin_src_out(pinl), .memif_clock_source_select_out(),
      .strap_fault_out());

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   // Classic cycle; the request holds until ack is sampled high
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      // Only the watchdog ends this wait; the latency is judged afterwards
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1);
      check(n, 2, "bus answer latency");
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : bus

   // New straps come with a fresh reset; wait for the decoded result
   task automatic apply(input logic [4:0] s);
      int n;
      @(posedge clk);
      sv <= s;
      wig <= 1'b0;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!(rst_n === 1'b1 && valid === 1'b1) && n < 20);
      check(valid, 1'b1, "capture done");
   endtask : apply

   task automatic decode(input logic [4:0] s);
      logic [1:0] b;
      b = s[3:2];
      check(order, s[0], "byte order");
      check(fixo, !s[0] && !s[1], "fix output");
      check({boot, emu}, {b, b == 2'b00}, "emulation boot");
      check({rom, w16}, {b == 2'b01 || b == 2'b10, b == 2'b10}, "rom boot");
      check({x4, pin}, {s[4], s[4]}, "clock strap");
      // Each variant must keep the other variant's clock output low
      check({x4l, pinl}, 2'b00, "variant gating");
      check(fault, b == 2'b11 || !s[4] || (!s[0] && s[1]), "strap fault");
      check(csel, 1'b0, "clock source reset");
   endtask : decode

   // ****************************************
   // Scenarios
   // ****************************************
   // Legal sets first; the last three break the board's side on purpose
   task automatic strap_table;
      logic [4:0] tab [7] = '{5'b10111, 5'b10100, 5'b10011, 5'b11011,
         5'b10110, 5'b11111, 5'b00111};
      logic [31:0] q;
      foreach (tab[i]) begin
         apply(tab[i]);
         decode(tab[i]);
         bus(1'b0, `CFG_WINDOW_FIRST, 32'h0, q);
         check(q, 32'h0, "config reset value");
      end
   endtask : strap_table

   task automatic hold;
      apply(5'b10111);
      wig <= 1'b1;
      repeat (8) @(posedge clk);
      decode(5'b10111);
      wig <= 1'b0;
   endtask : hold

   task automatic regs;
      logic [31:0] q;
      apply(5'b10111);
      // Status word: straps 10111 in bits 4:0, valid set, no fault
      bus(1'b0, `STATUS_ADDR, 32'h0, q);
      check(q, 32'h0000_0037, "status word");
      bus(1'b1, `CFG_WINDOW_FIRST, 32'h10, q);
      @(posedge clk);
      check(csel, 1'b1, "external clock picked");
      bus(1'b0, `CFG_WINDOW_FIRST, 32'h0, q);
      check(q, 32'h10, "config read back");
      bus(1'b1, 32'h019c0400, 32'h0, q);
      bus(1'b0, `CFG_WINDOW_LAST - 32'h3, 32'h0, q);
      check(q, 32'h10, "alias read after outside write");
      bus(1'b0, 32'h019c0400, 32'h0, q);
      check(q, 32'h0, "outside read");
      bus(1'b1, `CFG_WINDOW_LAST - 32'h3, 32'h0, q);
      @(posedge clk);
      check(csel, 1'b0, "alias write");
      bus(1'b1, `CFG_WINDOW_FIRST, 32'h10, q);
      apply(5'b10111);
      check(csel, 1'b0, "cleared by reset");
      // A write with byte lane 0 off must leave the select bit alone
      sel <= 4'he;
      bus(1'b1, `CFG_WINDOW_FIRST, 32'h10, q);
      sel <= 4'hf;
      @(posedge clk);
      check(csel, 1'b0, "write without lane zero ignored");
   endtask : regs

   // ****************************************
   // Run control
   // ****************************************
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test

   initial begin
      strap_table();
      hold();
      regs();
      stop_test();
   end

   // All scenarios need well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      stop_test();
   end
endmodule : reset_strap_device_config_test

`default_nettype wire
